// [common/sicl_pkg.sv]
// Constants and types of the servo I/O condition block.
// Assumes a 125 MHz core clock; setting times below are in milliseconds, the clock constants in picoseconds.
package sicl_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_PS = 8000;
  localparam int unsigned MS_PS         = 1000000000;
  localparam int unsigned MS_CYCLES     = MS_PS / CLK_PERIOD_PS;

  // ****************************************************************
  // Register indices (word addresses on the register port)
  // ****************************************************************
  localparam int          AW          = 5;
  localparam int          DW          = 16;
  localparam int          NIN         = 6;
  localparam int          NFN         = 4;
  localparam logic [4:0]  IDX_CTRL    = 5'h00;
  localparam logic [4:0]  IDX_OUT3    = 5'h01;
  localparam logic [4:0]  IDX_BD      = 5'h02;
  localparam logic [4:0]  IDX_BE      = 5'h03;
  localparam logic [4:0]  IDX_HX      = 5'h04;
  localparam logic [4:0]  IDX_FI1     = 5'h05;
  localparam logic [4:0]  IDX_PD      = 5'h0b;
  localparam logic [4:0]  IDX_PE      = 5'h0c;
  localparam logic [4:0]  IDX_ZV      = 5'h0d;
  localparam logic [4:0]  IDX_VR      = 5'h0e;
  localparam logic [4:0]  IDX_IRQ_STS = 5'h0f;
  localparam logic [4:0]  IDX_IRQ_MSK = 5'h10;
  localparam logic [4:0]  IDX_STATE   = 5'h11;
  localparam logic [4:0]  IDX_FN1     = 5'h12;

  // ****************************************************************
  // Reset values and legal ranges (speeds in 0.1 rps)
  // ****************************************************************
  localparam logic [15:0] BD_RST   = 16'h00c8;
  localparam logic [15:0] BE_RST   = 16'h00c8;
  localparam logic [15:0] HX_RST   = 16'h0004;
  localparam logic [15:0] FI_RST   = 16'h0002;
  localparam logic [15:0] PD_RST   = 16'h0028;
  localparam logic [15:0] PE_RST   = 16'h000a;
  localparam logic [15:0] ZV_RST   = 16'h0005;
  localparam logic [15:0] VR_RST   = 16'h0001;
  localparam logic [15:0] DLY_MAX  = 16'h7d00;
  localparam logic [15:0] FI_MAX   = 16'h1f40;
  localparam logic [15:0] PE_MAX   = 16'h7530;
  localparam logic [15:0] PD_MAX   = 16'h7d00;
  localparam logic [15:0] ZV_MIN   = 16'h0001;
  localparam logic [15:0] ZV_MAX   = 16'h0014;
  localparam logic [15:0] VR_MAX   = 16'h03e8;
  localparam logic [15:0] OUT3_GP  = 16'h0000;
  localparam logic [15:0] OUT3_BRK = 16'h0005;
  localparam logic [15:0] FN_HOME  = 16'h0010;
  localparam logic [15:0] FN_RST   = 16'h0000;

  // ****************************************************************
  // Interrupt bit positions
  // ****************************************************************
  localparam int IRQ_W          = 4;
  localparam int IRQ_STANDSTILL = 0;
  localparam int IRQ_VMATCH     = 1;
  localparam int IRQ_INPOS      = 2;
  localparam int IRQ_INCHG      = 3;

  typedef enum logic [1:0] {ST_OFF, ST_RELEASE, ST_RUN, ST_APPLY} sicl_brake_state_t;

  typedef struct packed {
    logic in_position;
    logic velocity_match;
    logic standstill;
  } sicl_flags_t;

endpackage

// [rtl/sicl_servo_io.sv]
// Servo I/O condition logic: brake sequencing, input filters, home sensor
// monitor, standstill / velocity match / in-position flags, interrupts.
// Assumes speed, position error and enable request come from logic on
// core_clk; digital input pins are asynchronous.
//
// The address-and-strobe port and the address map were left to the implementer.
`timescale 1ns/1ps
module sicl_servo_io #(
  parameter int unsigned MS_CYCLES = sicl_pkg::MS_CYCLES,
  parameter int          NIN       = sicl_pkg::NIN
) (
  // Clock and reset
  input  wire logic                     core_clk,
  input  wire logic                     rst_n,
  input  wire logic                     clk_en,
  // Register port
  input  wire logic [sicl_pkg::AW-1:0]  reg_addr,
  input  wire logic [sicl_pkg::DW-1:0]  reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic      [sicl_pkg::DW-1:0]  reg_rdata_ff,
  // Motion controller side
  input  wire logic                     enable_req,
  input  wire logic signed [15:0]       speed_act,
  input  wire logic signed [15:0]       speed_cmd,
  input  wire logic signed [15:0]       pos_err,
  output logic                          motion_permit_ff,
  output logic                          motor_enable_ff,
  output sicl_pkg::sicl_flags_t         flags_ff,
  // Pins
  input  wire logic [NIN-1:0]           din_pins,
  output logic      [NIN-1:0]           din_filt_ff,
  output logic                          brake_release_ff,
  output logic                          dout3_ff,
  output logic                          irq_ff
);

  localparam int PW = $clog2(MS_CYCLES + 1);

  // ****************************************************************
  // Millisecond timebase
  // ****************************************************************
  logic [PW-1:0] pre_ff;
  wire           ms_tick = (pre_ff == PW'(MS_CYCLES - 1));

  always_ff @(posedge core_clk)
    if (!rst_n)
      pre_ff <= '0;
    else if (clk_en)
      pre_ff <= ms_tick ? '0 : pre_ff + PW'(1);

  // ****************************************************************
  // Register file
  // ****************************************************************
  logic                        gp_out_ff;
  logic [15:0]                 out3_sel_ff;
  logic [15:0]                 bd_ff;
  logic [15:0]                 be_ff;
  logic [15:0]                 hx_ff;
  logic [15:0]                 deb_time_ff [NIN];
  logic [15:0]                 pd_ff;
  logic [15:0]                 pe_ff;
  logic [15:0]                 zv_ff;
  logic [15:0]                 vr_ff;
  logic [15:0]                 fn_sel_ff [sicl_pkg::NFN];
  logic [sicl_pkg::IRQ_W-1:0]  sts_ff;
  logic [sicl_pkg::IRQ_W-1:0]  msk_ff;
  logic [sicl_pkg::IRQ_W-1:0]  irq_set;
  sicl_pkg::sicl_brake_state_t state_ff;

  // Out-of-range writes are dropped so the stored setting stays legal
  wire wr_ctrl = reg_wr && (reg_addr == sicl_pkg::IDX_CTRL);
  wire wr_out3 = reg_wr && (reg_addr == sicl_pkg::IDX_OUT3)
                 && (reg_wdata == sicl_pkg::OUT3_GP || reg_wdata == sicl_pkg::OUT3_BRK);
  wire wr_bd   = reg_wr && (reg_addr == sicl_pkg::IDX_BD) && (reg_wdata <= sicl_pkg::DLY_MAX);
  wire wr_be   = reg_wr && (reg_addr == sicl_pkg::IDX_BE) && (reg_wdata <= sicl_pkg::DLY_MAX);
  wire wr_pd   = reg_wr && (reg_addr == sicl_pkg::IDX_PD) && (reg_wdata <= sicl_pkg::PD_MAX);
  wire wr_pe   = reg_wr && (reg_addr == sicl_pkg::IDX_PE) && (reg_wdata <= sicl_pkg::PE_MAX);
  wire wr_zv   = reg_wr && (reg_addr == sicl_pkg::IDX_ZV)
                 && (reg_wdata >= sicl_pkg::ZV_MIN) && (reg_wdata <= sicl_pkg::ZV_MAX);
  wire wr_vr   = reg_wr && (reg_addr == sicl_pkg::IDX_VR) && (reg_wdata <= sicl_pkg::VR_MAX);
  wire wr_sts  = reg_wr && (reg_addr == sicl_pkg::IDX_IRQ_STS);
  wire wr_msk  = reg_wr && (reg_addr == sicl_pkg::IDX_IRQ_MSK);
  wire fi_ok   = reg_wdata <= sicl_pkg::FI_MAX;

  always_ff @(posedge core_clk)
    if (!rst_n)
    begin
      gp_out_ff   <= 1'b0;
      out3_sel_ff <= sicl_pkg::OUT3_GP;
      bd_ff       <= sicl_pkg::BD_RST;
      be_ff       <= sicl_pkg::BE_RST;
      pd_ff       <= sicl_pkg::PD_RST;
      pe_ff       <= sicl_pkg::PE_RST;
      zv_ff       <= sicl_pkg::ZV_RST;
      vr_ff       <= sicl_pkg::VR_RST;
      msk_ff      <= '0;
      for (int i = 0; i < NIN; i++)
        deb_time_ff[i] <= sicl_pkg::FI_RST;
      for (int i = 0; i < sicl_pkg::NFN; i++)
        fn_sel_ff[i] <= sicl_pkg::FN_RST;
    end
    else if (clk_en)
    begin
      if (wr_ctrl) gp_out_ff <= reg_wdata[0];
      if (wr_out3) out3_sel_ff <= reg_wdata;
      if (wr_bd) bd_ff <= reg_wdata;
      if (wr_be) be_ff <= reg_wdata;
      if (wr_pd) pd_ff <= reg_wdata;
      if (wr_pe) pe_ff <= reg_wdata;
      if (wr_zv) zv_ff <= reg_wdata;
      if (wr_vr) vr_ff <= reg_wdata;
      if (wr_msk) msk_ff <= reg_wdata[sicl_pkg::IRQ_W-1:0];
      for (int i = 0; i < NIN; i++)
        if (reg_wr && fi_ok && reg_addr == sicl_pkg::IDX_FI1 + 5'(i))
          deb_time_ff[i] <= reg_wdata;
      for (int i = 0; i < sicl_pkg::NFN; i++)
        if (reg_wr && reg_addr == sicl_pkg::IDX_FN1 + 5'(i))
          fn_sel_ff[i] <= reg_wdata;
    end

  // ****************************************************************
  // Home sensor monitor
  // ****************************************************************
  // Lowest-numbered input wins; with none assigned the monitor shows 4.
  // A write to the monitor index is simply not decoded.
  logic [15:0] nxt_hx;
  always_comb
  begin
    nxt_hx = sicl_pkg::HX_RST;
    for (int i = sicl_pkg::NFN - 1; i >= 0; i--)
      if (fn_sel_ff[i] == sicl_pkg::FN_HOME)
        nxt_hx = 16'(i + 1);
  end

  always_ff @(posedge core_clk)
    if (!rst_n)
      hx_ff <= sicl_pkg::HX_RST;
    else if (clk_en)
      hx_ff <= nxt_hx;

  // ****************************************************************
  // Input synchronisers and filters
  // ****************************************************************
  // Filter counts whole ms ticks, so the first tick can come early by
  // up to 1 ms; a setting of 0 passes the input after the synchroniser.
  logic [NIN-1:0] sync1_ff;
  logic [NIN-1:0] sync2_ff;
  logic [15:0]    deb_cnt_ff [NIN];

  always_ff @(posedge core_clk)
    if (!rst_n)
    begin
      sync1_ff    <= '0;
      sync2_ff    <= '0;
      din_filt_ff <= '0;
      for (int i = 0; i < NIN; i++)
        deb_cnt_ff[i] <= '0;
    end
    else if (clk_en)
    begin
      sync1_ff <= din_pins;
      sync2_ff <= sync1_ff;
      for (int i = 0; i < NIN; i++)
        if (sync2_ff[i] == din_filt_ff[i])
          deb_cnt_ff[i] <= '0;
        else if (deb_cnt_ff[i] >= deb_time_ff[i])
        begin
          din_filt_ff[i] <= sync2_ff[i];
          deb_cnt_ff[i]  <= '0;
        end
        else if (ms_tick)
          deb_cnt_ff[i] <= deb_cnt_ff[i] + 16'h0001;
    end

  // ****************************************************************
  // Brake sequencing
  // ****************************************************************
  // A re-enable during the apply delay waits until the motor is off, so
  // the load is never left free between motor and brake.
  logic [15:0]                 brk_cnt_ff;
  logic [15:0]                 nxt_brk_cnt;
  sicl_pkg::sicl_brake_state_t nxt_state;
  logic                        nxt_release;
  logic                        nxt_enable;
  logic                        nxt_permit;

  always_comb
  begin
    nxt_state   = state_ff;
    nxt_brk_cnt = brk_cnt_ff;
    nxt_release = brake_release_ff;
    nxt_enable  = motor_enable_ff;
    nxt_permit  = motion_permit_ff;
    case (state_ff)
      sicl_pkg::ST_OFF:
        if (enable_req)
        begin
          nxt_state   = sicl_pkg::ST_RELEASE;
          nxt_enable  = 1'b1;
          nxt_release = 1'b1;
          nxt_brk_cnt = '0;
        end
      sicl_pkg::ST_RELEASE:
        if (!enable_req)
        begin
          nxt_state   = sicl_pkg::ST_APPLY;
          nxt_release = 1'b0;
          nxt_brk_cnt = '0;
        end
        else if (brk_cnt_ff >= bd_ff)
        begin
          nxt_state  = sicl_pkg::ST_RUN;
          nxt_permit = 1'b1;
        end
        else if (ms_tick)
          nxt_brk_cnt = brk_cnt_ff + 16'h0001;
      sicl_pkg::ST_RUN:
        if (!enable_req)
        begin
          nxt_state   = sicl_pkg::ST_APPLY;
          nxt_release = 1'b0;
          nxt_permit  = 1'b0;
          nxt_brk_cnt = '0;
        end
      sicl_pkg::ST_APPLY:
        if (brk_cnt_ff >= be_ff)
        begin
          nxt_state  = sicl_pkg::ST_OFF;
          nxt_enable = 1'b0;
        end
        else if (ms_tick)
          nxt_brk_cnt = brk_cnt_ff + 16'h0001;
      default:
        nxt_state = sicl_pkg::ST_OFF;
    endcase
  end

  always_ff @(posedge core_clk)
    if (!rst_n)
    begin
      state_ff         <= sicl_pkg::ST_OFF;
      brk_cnt_ff       <= '0;
      brake_release_ff <= 1'b0;
      motor_enable_ff  <= 1'b0;
      motion_permit_ff <= 1'b0;
      dout3_ff         <= 1'b0;
    end
    else if (clk_en)
    begin
      state_ff         <= nxt_state;
      brk_cnt_ff       <= nxt_brk_cnt;
      brake_release_ff <= nxt_release;
      motor_enable_ff  <= nxt_enable;
      motion_permit_ff <= nxt_permit;
      dout3_ff         <= (out3_sel_ff == sicl_pkg::OUT3_BRK) ? nxt_release : gp_out_ff;
    end

  // ****************************************************************
  // Motion condition flags
  // ****************************************************************
  function automatic logic [16:0] sicl_abs17(input logic signed [16:0] v);
    sicl_abs17 = v[16] ? 17'(-v) : 17'(v);
  endfunction

  wire logic [16:0] spd_abs = sicl_abs17(17'(speed_act));
  wire logic [16:0] vdif    = sicl_abs17(17'(speed_act) - 17'(speed_cmd));
  wire logic [16:0] perr    = sicl_abs17(17'(pos_err));
  // No mode input: the same compare holds in every control mode
  wire              cond_ss = spd_abs <= {1'b0, zv_ff};
  wire              cond_vm = vdif <= {1'b0, vr_ff};
  wire              cond_ip = perr <= {1'b0, pd_ff};
  logic [15:0]      qv_cnt_ff;
  logic [15:0]      qp_cnt_ff;

  always_ff @(posedge core_clk)
    if (!rst_n)
    begin
      flags_ff  <= '0;
      qv_cnt_ff <= '0;
      qp_cnt_ff <= '0;
    end
    else if (clk_en)
    begin
      flags_ff.standstill <= cond_ss;
      if (!cond_vm)
      begin
        qv_cnt_ff               <= '0;
        flags_ff.velocity_match <= 1'b0;
      end
      else if (qv_cnt_ff >= pe_ff)
        flags_ff.velocity_match <= 1'b1;
      else if (ms_tick)
        qv_cnt_ff <= qv_cnt_ff + 16'h0001;
      if (!cond_ip)
      begin
        qp_cnt_ff            <= '0;
        flags_ff.in_position <= 1'b0;
      end
      else if (qp_cnt_ff >= pe_ff)
        flags_ff.in_position <= 1'b1;
      else if (ms_tick)
        qp_cnt_ff <= qp_cnt_ff + 16'h0001;
    end

  // ****************************************************************
  // Interrupts and read port
  // ****************************************************************
  assign irq_set[sicl_pkg::IRQ_STANDSTILL] = cond_ss && !flags_ff.standstill;
  assign irq_set[sicl_pkg::IRQ_VMATCH]     = cond_vm && qv_cnt_ff >= pe_ff && !flags_ff.velocity_match;
  assign irq_set[sicl_pkg::IRQ_INPOS]      = cond_ip && qp_cnt_ff >= pe_ff && !flags_ff.in_position;
  assign irq_set[sicl_pkg::IRQ_INCHG]      = |(sync2_ff ^ din_filt_ff);

  wire [sicl_pkg::IRQ_W-1:0] sts_clr = wr_sts ? reg_wdata[sicl_pkg::IRQ_W-1:0] : '0;
  // Set wins over a write-one clear in the same cycle
  wire [sicl_pkg::IRQ_W-1:0] nxt_sts = (sts_ff & ~sts_clr) | irq_set;

  logic [15:0] rd_mux;
  always_comb
  begin
    rd_mux = '0;
    if (reg_addr == sicl_pkg::IDX_CTRL) rd_mux = {15'h0000, gp_out_ff};
    else if (reg_addr == sicl_pkg::IDX_OUT3) rd_mux = out3_sel_ff;
    else if (reg_addr == sicl_pkg::IDX_BD) rd_mux = bd_ff;
    else if (reg_addr == sicl_pkg::IDX_BE) rd_mux = be_ff;
    else if (reg_addr == sicl_pkg::IDX_HX) rd_mux = hx_ff;
    else if (reg_addr >= sicl_pkg::IDX_FI1 && reg_addr < sicl_pkg::IDX_FI1 + 5'(NIN))
      rd_mux = deb_time_ff[3'(reg_addr - sicl_pkg::IDX_FI1)];
    else if (reg_addr == sicl_pkg::IDX_PD) rd_mux = pd_ff;
    else if (reg_addr == sicl_pkg::IDX_PE) rd_mux = pe_ff;
    else if (reg_addr == sicl_pkg::IDX_ZV) rd_mux = zv_ff;
    else if (reg_addr == sicl_pkg::IDX_VR) rd_mux = vr_ff;
    else if (reg_addr == sicl_pkg::IDX_IRQ_STS) rd_mux = 16'(sts_ff);
    else if (reg_addr == sicl_pkg::IDX_IRQ_MSK) rd_mux = 16'(msk_ff);
    else if (reg_addr == sicl_pkg::IDX_STATE)
      rd_mux = {8'h00, 2'(state_ff), motion_permit_ff, motor_enable_ff, brake_release_ff, flags_ff};
    else if (reg_addr >= sicl_pkg::IDX_FN1 && reg_addr < sicl_pkg::IDX_FN1 + 5'(sicl_pkg::NFN))
      rd_mux = fn_sel_ff[2'(reg_addr - sicl_pkg::IDX_FN1)];
  end

  always_ff @(posedge core_clk)
    if (!rst_n)
    begin
      sts_ff       <= '0;
      irq_ff       <= 1'b0;
      reg_rdata_ff <= '0;
    end
    else if (clk_en)
    begin
      sts_ff       <= nxt_sts;
      irq_ff       <= |(nxt_sts & msk_ff);
      reg_rdata_ff <= reg_rd ? rd_mux : '0;
    end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_motion_needs_brake: assert property (@(posedge core_clk) disable iff (!rst_n)
    motion_permit_ff |-> brake_release_ff && motor_enable_ff)
    else $error("Motion permitted with brake applied or motor off");
  a_release_delay_met: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(motion_permit_ff) |-> $past(brk_cnt_ff) >= $past(bd_ff))
    else $error("Motion permitted before release delay");
  a_disable_after_apply: assert property (@(posedge core_clk) disable iff (!rst_n)
    $fell(motor_enable_ff) |-> !brake_release_ff && !$past(brake_release_ff) && $past(brk_cnt_ff) >= $past(be_ff))
    else $error("Motor disabled before brake delay");
  a_load_held: assert property (@(posedge core_clk) disable iff (!rst_n)
    !motor_enable_ff |-> !brake_release_ff)
    else $error("Load free: brake released with motor off");
  a_home_mon_range: assert property (@(posedge core_clk) disable iff (!rst_n)
    hx_ff >= 16'h0001 && hx_ff <= 16'h0004)
    else $error("Home monitor out of range");
  a_out3_code_legal: assert property (@(posedge core_clk) disable iff (!rst_n)
    out3_sel_ff == sicl_pkg::OUT3_GP || out3_sel_ff == sicl_pkg::OUT3_BRK)
    else $error("Illegal output three code");
  a_standstill_set: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && spd_abs <= {1'b0, zv_ff} |=> flags_ff.standstill)
    else $error("Standstill flag missing inside window");
  a_standstill_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && spd_abs > {1'b0, zv_ff} |=> !flags_ff.standstill)
    else $error("Standstill flag set outside window");
  a_vmatch_qualified: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(flags_ff.velocity_match) |-> $past(cond_vm) && $past(qv_cnt_ff) >= $past(pe_ff))
    else $error("Velocity match before qualification time");
  a_vmatch_drop: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && !cond_vm |=> !flags_ff.velocity_match && qv_cnt_ff == 16'h0000)
    else $error("Velocity match kept after condition lost");
  a_filter_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
    $changed(din_filt_ff[0]) |-> $past(deb_cnt_ff[0]) >= $past(deb_time_ff[0]))
    else $error("Input passed before filter time");

endmodule

// [verif/sicl_motor_model.sv]
// Motor model on the far side of the servo I/O block.
// Assumes one core clock; speed is in 0.1 rps units.
`timescale 1ns/1ps
module sicl_motor_model (
  // Clock and reset
  input  wire logic               core_clk,
  input  wire logic               rst_n,
  // Drive side
  input  wire logic               permit,
  input  wire logic signed [15:0] speed_cmd,
  input  wire logic signed [15:0] skew,
  output logic signed      [15:0] speed_act
);
  // ***************
  // Shaft speed
  // ***************
  // Follows command only while motion is permitted; otherwise only creep
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      speed_act <= 16'sh0000;
    else
      speed_act <= permit ? speed_cmd + skew : skew;
  end
endmodule

// [verif/tb_top.sv]
// Self-checking bench for the servo I/O condition block.
// Assumes a 1 ms timebase shortened to 10 clock cycles.
`timescale 1ns/1ps
module tb_top;
  // ***************
  // Signals
  // ***************
  logic                  core_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, enable_req = 0;
  logic [4:0]            reg_addr = 5'h00;
  logic [15:0]           reg_wdata = 16'h0000, reg_rdata_ff;
  logic signed [15:0]    speed_cmd = 16'sh0000, speed_act, skew = 16'sh0000, pos_err = 16'sh0029;
  logic [5:0]            din_pins = 6'h00, din_filt_ff;
  logic                  motion_permit_ff, motor_enable_ff, brake_release_ff, dout3_ff, irq_ff;
  sicl_pkg::sicl_flags_t flags_ff;
  int                    fails = 0, n_tests = 0, cyc, k;
  wire [7:0] mon = {din_filt_ff[2], flags_ff.in_position, flags_ff.velocity_match, flags_ff.standstill,
                    irq_ff, motion_permit_ff, !motor_enable_ff, motor_enable_ff};

  always #4 core_clk = ~core_clk;

  sicl_servo_io #(.MS_CYCLES(10)) dut_u (.core_clk(core_clk), .rst_n(rst_n), .clk_en(1'b1),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
    .enable_req(enable_req), .speed_act(speed_act), .speed_cmd(speed_cmd), .pos_err(pos_err),
    .motion_permit_ff(motion_permit_ff), .motor_enable_ff(motor_enable_ff), .flags_ff(flags_ff),
    .din_pins(din_pins), .din_filt_ff(din_filt_ff), .brake_release_ff(brake_release_ff),
    .dout3_ff(dout3_ff), .irq_ff(irq_ff));
  sicl_motor_model mot_u (.core_clk(core_clk), .rst_n(rst_n), .permit(motion_permit_ff),
    .speed_cmd(speed_cmd), .skew(skew), .speed_act(speed_act));

  // ***************
  // Tasks
  // ***************
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Strobes drop on an edge of their own, so back-to-back calls never collide
  task wr(input logic [4:0] a, input logic [15:0] d);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge core_clk); reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask
  task rd(input logic [4:0] a, input logic [15:0] e);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge core_clk); reg_rd <= 1'b0;
    #1 chk(reg_rdata_ff, e);
    @(posedge core_clk);
  endtask
  task wt(input int b, input int lim);
    cyc = 0;
    while (mon[b] !== 1'b1 && cyc < lim)
    begin
      @(posedge core_clk); #1 cyc++;
    end
    @(posedge core_clk);
  endtask
  task final_report;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ***************
  // Tests
  // ***************
  initial
  begin
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    rd(5'h01, 16'h0000); rd(5'h02, 16'h00c8); rd(5'h03, 16'h00c8); rd(5'h04, 16'h0004);
    for (k = 5; k < 11; k++) rd(5'(k), 16'h0002);
    rd(5'h0b, 16'h0028); rd(5'h0c, 16'h000a); rd(5'h1f, 16'h0000);
    wr(5'h01, 16'h0003); rd(5'h01, 16'h0000); wr(5'h01, 16'h0005); rd(5'h01, 16'h0005);
    wr(5'h04, 16'h0001); rd(5'h04, 16'h0004);
    rd(5'h0d, 16'h0005); wr(5'h0d, 16'h0015); rd(5'h0d, 16'h0005); wr(5'h0d, 16'h0000); rd(5'h0d, 16'h0005);
    rd(5'h0e, 16'h0001); wr(5'h0e, 16'h03e9); rd(5'h0e, 16'h0001);
    wr(5'h02, 16'h7d01); rd(5'h02, 16'h00c8); wr(5'h03, 16'h7d01); rd(5'h03, 16'h00c8);
    wr(5'h06, 16'h1f41); rd(5'h06, 16'h0002); wr(5'h0c, 16'h7531); rd(5'h0c, 16'h000a);
    wr(5'h0b, 16'h7d01); rd(5'h0b, 16'h0028);
    wr(5'h14, 16'h0010); rd(5'h04, 16'h0003);
    wr(5'h02, 16'h0003); wr(5'h03, 16'h0003); wr(5'h0c, 16'h0002); wr(5'h07, 16'h0002); wr(5'h05, 16'h0000);
    $display("test registers done");
    enable_req <= 1'b1;
    wt(0, 10);
    chk(motion_permit_ff, 0); chk(dout3_ff, 1);
    wt(2, 60);
    chk(16'(cyc >= 19), 1); chk(motion_permit_ff, 1);
    speed_cmd <= 16'sd50; skew <= 16'sd1; pos_err <= 16'sd40;
    repeat (5) @(posedge core_clk);
    #1 chk(flags_ff.velocity_match, 0);
    @(posedge core_clk);
    wt(5, 40);
    chk(flags_ff.velocity_match, 1); chk(flags_ff.in_position, 1);
    skew <= 16'sd2; pos_err <= -16'sd41;
    repeat (3) @(posedge core_clk);
    #1 chk(flags_ff.velocity_match, 0); chk(flags_ff.in_position, 0);
    @(posedge core_clk);
    enable_req <= 1'b0;
    @(posedge core_clk);
    #1 chk(brake_release_ff, 0); chk(motor_enable_ff, 1);
    @(posedge core_clk);
    wt(1, 60);
    chk(16'(cyc >= 18), 1);
    $display("test brake done");
    wr(5'h10, 16'h0001); skew <= 16'sd6;
    repeat (4) @(posedge core_clk);
    #1 chk(flags_ff.standstill, 0);
    @(posedge core_clk);
    wr(5'h0f, 16'h000f); skew <= -16'sd5;
    wt(3, 8);
    chk(flags_ff.standstill, 1); chk(irq_ff, 1);
    wr(5'h0f, 16'h0001);
    #1 chk(irq_ff, 0);
    @(posedge core_clk);
    $display("test standstill done");
    din_pins <= 6'h05;
    repeat (6) @(posedge core_clk);
    #1 chk(din_filt_ff[0], 1); chk(din_filt_ff[2], 0);
    @(posedge core_clk);
    wt(7, 40);
    chk(din_filt_ff[2], 1);
    $display("test inputs done");
    final_report;
  end

  initial
  begin
    repeat (5000) @(posedge core_clk);
    fails++;
    final_report;
  end
endmodule
